// ===== hdl/rtc_ctrl_pkg.sv
package rtc_ctrl_pkg;

  // ====================================================================
  // Register map
  localparam int ADDR_W = 8;
  localparam logic [3:0] GROUP_CTRL1 = 4'h0;
  localparam logic [3:0] GROUP_CTRL2 = 4'h1;
  localparam logic [3:0] GROUP_STAT = 4'h2;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_CLR = 2'h1;
  localparam logic [1:0] OP_SET = 2'h2;
  localparam logic [1:0] OP_INV = 2'h3;
  localparam logic [31:0] CTRL1_MASK = 32'hCFFF_88F0;
  localparam logic [31:0] CTRL2_MASK = 32'hFFFF_F833;
  localparam logic [31:0] CTRL1_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL2_RESET = 32'h0000_0000;

  // ====================================================================
  // Field positions
  localparam int ALRM_EN_BIT = 31;
  localparam int CHIME_BIT = 30;
  localparam int INTERVAL_LSB = 24;
  localparam int REPEAT_LSB = 16;
  localparam int MODULE_ON_BIT = 15;
  localparam int GUARD_BIT = 11;
  localparam int PIN_OE_BIT = 7;
  localparam int PIN_SEL_LSB = 4;
  localparam int DIV_LSB = 16;
  localparam int TRIM_LSB = 11;
  localparam int PRESCALE_LSB = 4;
  localparam int SOURCE_LSB = 0;
  localparam int HAPPENED_BIT = 5;
  localparam int TSYNC_BIT = 2;
  localparam int APEND_BIT = 1;
  localparam int HALF_BIT = 0;

  // ====================================================================
  // Encodings
  localparam logic [3:0] IV_HALF = 4'h0;
  localparam logic [3:0] IV_SECOND = 4'h1;
  localparam logic [3:0] IV_TEN_SEC = 4'h2;
  localparam logic [3:0] IV_MINUTE = 4'h3;
  localparam logic [3:0] IV_TEN_MIN = 4'h4;
  localparam logic [3:0] IV_HOUR = 4'h5;
  localparam logic [3:0] IV_DAY = 4'h6;
  localparam logic [3:0] IV_WEEK = 4'h7;
  localparam logic [3:0] IV_MONTH = 4'h8;
  localparam logic [3:0] IV_YEAR = 4'h9;
  localparam logic [2:0] PIN_ALARM = 3'h0;
  localparam logic [2:0] PIN_SECONDS = 3'h1;
  localparam logic [2:0] PIN_DIVIDED = 3'h2;
  localparam logic [1:0] SRC_PERIPH = 2'h3;
  localparam logic [7:0] REPEAT_FULL = 8'hFF;
  localparam logic [4:0] TRIM_LAST_HALF = 5'h1F;

  // BCD field masks of the time and date words.
  localparam logic [31:0] SEC_ONES_MASK = 32'h0000_0F00;
  localparam logic [31:0] SEC_MASK = 32'h0000_FF00;
  localparam logic [31:0] MIN_ONES_MASK = 32'h000F_0000;
  localparam logic [31:0] MIN_MASK = 32'h007F_0000;
  localparam logic [31:0] HOUR_MASK = 32'h7F00_0000;
  localparam logic [31:0] WDAY_MASK = 32'h0000_0007;
  localparam logic [31:0] DAY_MASK = 32'h0000_3F00;
  localparam logic [31:0] MONTH_MASK = 32'h001F_0000;

  // ====================================================================
  // Timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int SYNC_SETTLE_NS = 64;
  localparam int SYNC_SETTLE_CYCLES = (SYNC_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] SETTLE_LOAD = 4'(SYNC_SETTLE_CYCLES);

  typedef enum logic {DIV_COUNT, DIV_STRETCH} divider_state_t;

  function automatic logic [31:0] apply_alias(input logic [31:0] old, input logic [31:0] data,
                                              input logic [1:0] op);
    logic [31:0] r;
    r = data;
    if (op == OP_CLR) begin
      r = old & ~data;
    end else if (op == OP_SET) begin
      r = old | data;
    end else if (op == OP_INV) begin
      r = old ^ data;
    end
    return r;
  endfunction

  function automatic logic [7:0] prescale_last(input logic [1:0] sel);
    logic [7:0] r;
    case (sel)
      2'h1: r = 8'h0F;
      2'h2: r = 8'h3F;
      2'h3: r = 8'hFF;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

endpackage

// ===== hdl/pin_level_filter.sv
`timescale 1ns/1ps
module pin_level_filter #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] i_pins,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_rise
);

  logic [WIDTH-1:0] sync_a;
  logic [WIDTH-1:0] sync_b;
  logic [WIDTH-1:0] sync_c;
  logic [WIDTH-1:0] agree;

  // A level only moves once the second and third stages agree.
  assign agree = ~(sync_b ^ sync_c);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
      o_level <= '0;
      o_rise <= '0;
    end else begin
      sync_a <= i_pins;
      sync_b <= sync_a;
      sync_c <= sync_b;
      o_level <= (agree & sync_c) | (~agree & o_level);
      o_rise <= agree & sync_c & ~o_level;
    end
  end

endmodule // pin_level_filter

// ===== hdl/alarm_matcher.sv
`timescale 1ns/1ps
module alarm_matcher
  import rtc_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic i_eval,
  input wire logic i_whole_second,
  input wire logic [3:0] i_code,
  input wire logic [31:0] i_time,
  input wire logic [31:0] i_date,
  input wire logic [31:0] i_alarm_time,
  input wire logic [31:0] i_alarm_date,
  output logic o_match
);

  logic [31:0] tmask;
  logic [31:0] dmask;
  logic hit;

  always_comb begin
    tmask = '0;
    dmask = '0;
    hit = i_eval & i_whole_second;
    case (i_code) // R5
      IV_HALF: hit = i_eval;
      IV_SECOND: tmask = '0;
      IV_TEN_SEC: tmask = SEC_ONES_MASK;
      IV_MINUTE: tmask = SEC_MASK;
      IV_TEN_MIN: tmask = SEC_MASK | MIN_ONES_MASK;
      IV_HOUR: tmask = SEC_MASK | MIN_MASK;
      IV_DAY: tmask = SEC_MASK | MIN_MASK | HOUR_MASK;
      IV_WEEK: begin
        tmask = SEC_MASK | MIN_MASK | HOUR_MASK;
        dmask = WDAY_MASK;
      end
      IV_MONTH: begin
        tmask = SEC_MASK | MIN_MASK | HOUR_MASK;
        dmask = DAY_MASK;
      end
      IV_YEAR: begin
        // A 29th of February only exists in leap years, so it matches every fourth year.
        tmask = SEC_MASK | MIN_MASK | HOUR_MASK;
        dmask = DAY_MASK | MONTH_MASK; // R6
      end
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      o_match <= 1'b0;
    end else begin
      o_match <= hit && (((i_time ^ i_alarm_time) & tmask) == '0) && (((i_date ^ i_alarm_date) & dmask) == '0);
    end
  end

endmodule // alarm_matcher

// ===== hdl/rtc_alarm_control_status.sv
`timescale 1ns/1ps
// Operation
// R1: Alarm events occur only while alarm_enable is set.
// R2: With chime on the repeat count wraps 00 to FF, otherwise holds at 00.
// R3: Each alarm event decrements the eight-bit repeat count by one.
// R4: The repeat count gives how many more alarms follow, zero to 255.
// R5: The interval code picks the match period, half-second up to year.
// R6: A yearly alarm on February 29 fires once every four years.
// R7: With module enable set the clock counts; clear stops clock and calendar.
// R8: While the guard bit is set, writes to timekeeping registers are blocked.
// R9: Output enable drives the chosen signal on the pin, else pin disabled.
// R10: Pin choice 000 alarm pulse, 001 seconds clock, 010 divided clock.
// R11: The sixteen-bit divide field sets the divider counter period.
// R12: Nonzero trim N adds N input cycles once every 16 seconds; the divider nets only N rounded down to a multiple of the prescale factor.
// R13: Prescale divides the input clock by 1, 16, 64 or 256.
// R14: Source choice picks crystal, low-power RC, low-frequency pin or peripheral clock.
// R15: Read-only alarm-happened flag set on alarm, cleared by hardware.
// R16: Read-only time sync flag is high while time may change.
// R17: Alarm update flag high while enable and count may change; software waits.
// R18: Half-second flag reads 0 in first half, 1 in second half.
// R19: Unimplemented bits read zero and ignore writes.
// R20: Control registers have clear, set and invert aliases at 0x4, 0x8, 0xC.
// R21: An alarm with count zero and chime off clears alarm_enable.
module rtc_alarm_control_status
  import rtc_ctrl_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WRITE,
  input wire logic I_READ,
  output logic [31:0] O_RDATA,
  input wire logic I_CRYSTAL_OSC_32K,
  input wire logic I_INTERNAL_LOW_RC,
  input wire logic I_LOW_FREQ_CLK_PIN,
  input wire logic [31:0] I_TIME_VALUE,
  input wire logic [31:0] I_DATE_VALUE,
  input wire logic [31:0] I_ALARM_TIME_VALUE,
  input wire logic [31:0] I_ALARM_DATE_VALUE,
  output logic O_HALF_TICK,
  output logic O_SECOND_TICK,
  output logic O_CALENDAR_RUN,
  output logic O_TIMEKEEP_WRITE_OK,
  output logic O_ALARM_PULSE,
  output logic O_CLOCK_PIN,
  output logic O_CLOCK_PIN_OE
);

  // ====================================================================
  // Register storage and field views
  logic [31:0] ctrl1;
  logic [31:0] ctrl2;
  logic [31:0] next_ctrl1;
  logic [31:0] next_ctrl2;
  logic alarm_enable;
  logic chime;
  logic [3:0] alarm_interval_code;
  logic [7:0] alarm_repeat_count;
  logic module_on;
  logic timekeeping_guard;
  logic clock_pin_out_en;
  logic [2:0] pin_signal_choice;
  logic [15:0] divide;
  logic [4:0] fractional_trim;
  logic [1:0] prescale_sel;
  logic [1:0] source_choice;

  assign alarm_enable = ctrl1[ALRM_EN_BIT];
  assign chime = ctrl1[CHIME_BIT];
  assign alarm_interval_code = ctrl1[INTERVAL_LSB +: 4];
  assign alarm_repeat_count = ctrl1[REPEAT_LSB +: 8];
  assign module_on = ctrl1[MODULE_ON_BIT];
  assign timekeeping_guard = ctrl1[GUARD_BIT];
  assign clock_pin_out_en = ctrl1[PIN_OE_BIT];
  assign pin_signal_choice = ctrl1[PIN_SEL_LSB +: 3];
  assign divide = ctrl2[DIV_LSB +: 16];
  assign fractional_trim = ctrl2[TRIM_LSB +: 5];
  assign prescale_sel = ctrl2[PRESCALE_LSB +: 2];
  assign source_choice = ctrl2[SOURCE_LSB +: 2];

  // ====================================================================
  // Bus decode
  logic [3:0] group;
  logic [1:0] op;
  logic aligned;
  logic wr_ctrl1;
  logic wr_ctrl2;

  assign group = I_ADDR[7:4];
  assign op = I_ADDR[3:2];
  assign aligned = (I_ADDR[1:0] == 2'h0);
  assign wr_ctrl1 = I_WRITE && aligned && (group == GROUP_CTRL1);
  // Divider setup is timekeeping state, so the guard shields it as well.
  assign wr_ctrl2 = I_WRITE && aligned && (group == GROUP_CTRL2) && !timekeeping_guard; // R8

  // ====================================================================
  // Clock source selection and prescaler
  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  logic source_tick;
  logic [7:0] pre_cnt;
  logic pre_tick;
  logic div_toggle;

  pin_level_filter #(
    .WIDTH(3)
  ) u_pin_filter (
    .clk(I_CLK),
    .reset_n(I_RESET_N),
    .i_pins({I_LOW_FREQ_CLK_PIN, I_INTERNAL_LOW_RC, I_CRYSTAL_OSC_32K}),
    .o_level(pin_level),
    .o_rise(pin_rise)
  );

  // The peripheral clock is this clock, so every cycle is one input clock edge.
  always_comb begin
    if (source_choice == SRC_PERIPH) begin
      source_tick = 1'b1; // R14
    end else begin
      source_tick = pin_rise[source_choice]; // R14
    end
  end

  assign pre_tick = module_on && source_tick && (pre_cnt >= prescale_last(prescale_sel)); // R13

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pre_cnt <= 8'h00;
    end else if (module_on && source_tick) begin // R7
      if (pre_tick) begin
        pre_cnt <= 8'h00; // R13
      end else begin
        pre_cnt <= 8'(pre_cnt + 8'h01);
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      div_toggle <= 1'b0;
    end else if (pre_tick) begin
      div_toggle <= ~div_toggle;
    end
  end

  // ====================================================================
  // Half-second divider with fractional stretch
  divider_state_t div_state;
  logic [15:0] div_cnt;
  logic [4:0] stretch_left;
  logic [4:0] half_count;
  logic half_phase;
  logic div_end;
  logic trim_due;
  logic half_fire;

  assign div_end = pre_tick && (div_cnt >= divide); // R11
  assign trim_due = (half_count == TRIM_LAST_HALF) && (fractional_trim != 5'h00); // R12

  always_comb begin
    half_fire = 1'b0;
    case (div_state)
      DIV_COUNT: half_fire = div_end && !trim_due;
      DIV_STRETCH: half_fire = module_on && source_tick && (stretch_left == 5'h01); // R12
      default: half_fire = 1'b0;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      div_state <= DIV_COUNT;
      div_cnt <= 16'h0000;
      stretch_left <= 5'h00;
    end else begin
      case (div_state)
        DIV_COUNT: begin
          if (div_end) begin
            div_cnt <= 16'h0000; // R11
            if (trim_due) begin
              div_state <= DIV_STRETCH;
              stretch_left <= fractional_trim; // R12
            end
          end else if (pre_tick) begin
            div_cnt <= 16'(div_cnt + 16'h0001);
          end
        end
        DIV_STRETCH: begin
          if (module_on && source_tick) begin // R7
            stretch_left <= 5'(stretch_left - 5'h01);
            if (stretch_left == 5'h01) begin
              div_state <= DIV_COUNT;
            end
          end
        end
        default: div_state <= DIV_COUNT;
      endcase
    end
  end

  // The half counter spans 32 halves, so the trim lands once per 16 seconds.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      half_count <= 5'h00;
      half_phase <= 1'b0;
    end else if (half_fire) begin
      half_count <= 5'(half_count + 5'h01);
      half_phase <= ~half_phase; // R18
    end
  end

  // ====================================================================
  // Update window and alarm evaluation
  logic [3:0] settle;
  logic whole_second;
  logic time_sync;
  logic alarm_update_pending;
  logic match;
  logic alarm_hit;

  // The calendar changes after each tick; hold the sync flag until it settles.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      settle <= 4'h0;
      whole_second <= 1'b0;
    end else if (half_fire) begin
      settle <= SETTLE_LOAD;
      whole_second <= half_phase;
    end else if (settle != 4'h0) begin
      settle <= 4'(settle - 4'h1);
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      time_sync <= 1'b0;
      alarm_update_pending <= 1'b0;
    end else begin
      time_sync <= module_on && ((div_state == DIV_STRETCH) || (div_cnt >= divide) || (settle != 4'h0)); // R16
      alarm_update_pending <= module_on && alarm_enable && ((settle != 4'h0) || (div_cnt >= divide)); // R17
    end
  end

  // Comparing in the last cycle of the settle window (settle == 1) sees the time the calendar has just written.
  alarm_matcher u_matcher (
    .clk(I_CLK),
    .reset_n(I_RESET_N),
    .i_eval(settle == 4'h1),
    .i_whole_second(whole_second),
    .i_code(alarm_interval_code),
    .i_time(I_TIME_VALUE),
    .i_date(I_DATE_VALUE),
    .i_alarm_time(I_ALARM_TIME_VALUE),
    .i_alarm_date(I_ALARM_DATE_VALUE),
    .o_match(match)
  );

  assign alarm_hit = match && alarm_enable && module_on; // R1

  // ====================================================================
  // Control register updates
  // Hardware repeat and enable updates win over a software write in the same cycle.
  always_comb begin
    next_ctrl1 = ctrl1;
    if (wr_ctrl1) begin
      next_ctrl1 = apply_alias(ctrl1, I_WDATA, op) & CTRL1_MASK; // R20 R19
    end
    if (alarm_hit) begin
      if (alarm_repeat_count != 8'h00) begin
        next_ctrl1[REPEAT_LSB +: 8] = 8'(alarm_repeat_count - 8'h01); // R3 R4
      end else if (chime) begin
        next_ctrl1[REPEAT_LSB +: 8] = REPEAT_FULL; // R2
      end else begin
        next_ctrl1[REPEAT_LSB +: 8] = 8'h00; // R2
        next_ctrl1[ALRM_EN_BIT] = 1'b0; // R21
      end
    end
  end

  always_comb begin
    next_ctrl2 = ctrl2;
    if (wr_ctrl2) begin
      next_ctrl2 = apply_alias(ctrl2, I_WDATA, op) & CTRL2_MASK; // R20 R19
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ctrl1 <= CTRL1_RESET;
      ctrl2 <= CTRL2_RESET;
    end else begin
      ctrl1 <= next_ctrl1;
      ctrl2 <= next_ctrl2;
    end
  end

  // ====================================================================
  // Status flags
  logic alarm_happened;

  // Set on an alarm, cleared by hardware at the next half-second without one.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      alarm_happened <= 1'b0;
    end else if (alarm_hit) begin
      alarm_happened <= 1'b1; // R15
    end else if (half_fire) begin
      alarm_happened <= 1'b0; // R15
    end
  end

  // ====================================================================
  // Read path
  logic [31:0] read_word;

  always_comb begin
    read_word = '0;
    if (!aligned) begin
      read_word = '0;
    end else if (group == GROUP_CTRL1) begin
      read_word = ctrl1;
    end else if (group == GROUP_CTRL2) begin
      read_word = ctrl2;
    end else if (group == GROUP_STAT && op == OP_WRITE) begin
      read_word[HAPPENED_BIT] = alarm_happened; // R15
      read_word[TSYNC_BIT] = time_sync; // R16
      read_word[APEND_BIT] = alarm_update_pending; // R17
      read_word[HALF_BIT] = half_phase; // R18
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_RDATA <= '0;
    end else if (I_READ) begin
      O_RDATA <= read_word; // R19
    end else begin
      O_RDATA <= '0;
    end
  end

  // ====================================================================
  // Outputs toward calendar and pin
  logic pin_value;

  always_comb begin
    case (pin_signal_choice) // R10
      PIN_ALARM: pin_value = alarm_hit;
      PIN_SECONDS: pin_value = ~half_phase;
      PIN_DIVIDED: pin_value = div_toggle;
      default: pin_value = 1'b0;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_HALF_TICK <= 1'b0;
      O_SECOND_TICK <= 1'b0;
      O_CALENDAR_RUN <= 1'b0;
      O_TIMEKEEP_WRITE_OK <= 1'b0;
      O_ALARM_PULSE <= 1'b0;
      O_CLOCK_PIN <= 1'b0;
      O_CLOCK_PIN_OE <= 1'b0;
    end else begin
      O_HALF_TICK <= half_fire;
      O_SECOND_TICK <= half_fire && half_phase;
      O_CALENDAR_RUN <= module_on; // R7
      O_TIMEKEEP_WRITE_OK <= !timekeeping_guard; // R8
      O_ALARM_PULSE <= alarm_hit;
      O_CLOCK_PIN <= clock_pin_out_en && pin_value; // R9
      O_CLOCK_PIN_OE <= clock_pin_out_en; // R9
    end
  end

endmodule // rtc_alarm_control_status

// ===== sim/rtc_alarm_control_status_asserts.sv
`timescale 1ns/1ps
module rtc_alarm_control_status_asserts
  import rtc_ctrl_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WRITE,
  input wire logic I_READ,
  input wire logic [31:0] O_RDATA,
  input wire logic O_HALF_TICK,
  input wire logic O_SECOND_TICK,
  input wire logic O_CALENDAR_RUN,
  input wire logic O_TIMEKEEP_WRITE_OK,
  input wire logic O_ALARM_PULSE,
  input wire logic O_CLOCK_PIN,
  input wire logic O_CLOCK_PIN_OE
);
  // ====================================================================
  // Checks
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  a_rdata_idle: assert property (!$past(I_READ) |-> O_RDATA == 32'h0000_0000)
    else $error("read data not zero outside a read");
  a_ctrl1_unused: assert property ($past(I_READ) && $past(I_ADDR[7:4]) == GROUP_CTRL1 |-> (O_RDATA & ~CTRL1_MASK) == 0)
    else $error("unused control bits read nonzero");
  a_stat_unused: assert property ($past(I_READ) && $past(I_ADDR) == 8'h20 |-> !O_RDATA[31:6] && !O_RDATA[4:3])
    else $error("unused status bits read nonzero");
  a_unaligned_zero: assert property ($past(I_READ) && $past(I_ADDR[1:0]) != 2'h0 |-> O_RDATA == 0)
    else $error("unaligned read not zero");
  a_run_follow: assert property (I_WRITE && I_ADDR == 8'h00 |-> ##2 O_CALENDAR_RUN == $past(I_WDATA[MODULE_ON_BIT], 2))
    else $error("run level does not follow enable");
  a_guard_follow: assert property (I_WRITE && I_ADDR == 8'h00 |-> ##2 O_TIMEKEEP_WRITE_OK == !$past(I_WDATA[GUARD_BIT], 2))
    else $error("write permission does not follow guard");
  a_pin_quiet: assert property (!O_CLOCK_PIN_OE |-> !O_CLOCK_PIN)
    else $error("pin active while disabled");
  a_alarm_single: assert property (O_ALARM_PULSE |=> !O_ALARM_PULSE)
    else $error("alarm pulse longer than one cycle");
  a_alarm_running: assert property (O_ALARM_PULSE |-> O_CALENDAR_RUN)
    else $error("alarm while stopped");
  a_halted_quiet: assert property (!O_CALENDAR_RUN && !$past(O_CALENDAR_RUN) |-> !O_HALF_TICK)
    else $error("time base moves while stopped");
  a_second_half: assert property (O_SECOND_TICK |-> O_HALF_TICK)
    else $error("second tick off a half boundary");
  c_alarm: cover property (O_ALARM_PULSE);
  c_second: cover property (O_SECOND_TICK);
  c_pin: cover property (O_CLOCK_PIN_OE && O_CLOCK_PIN);
endmodule // rtc_alarm_control_status_asserts

// ===== sim/test_rtc_alarm_control_status.sv
`timescale 1ns/1ps
module test_rtc_alarm_control_status
  import rtc_ctrl_pkg::*;
;
  typedef struct packed {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} row_t;
  logic clk = 0, reset_n = 0, write = 0, read = 0, osc = 0, lrc = 0, lfp = 0;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0, rdata, d, date = '0, adate = '0, atime = 32'h0000_0100;
  logic half, sec, run, wok, alarm, pin, oe;
  int error_cnt = 0, num_checks = 0, cyc = 0, n_alarm, n_rise, n_half, per, sum;
  row_t rows[11] = '{'{8'h10, 32'hFFFF_FFFF, 8'h10, CTRL2_MASK}, '{8'h14, 32'h0000_0030, 8'h10, 32'hFFFF_F803},
    '{8'h18, 32'h0000_0030, 8'h10, CTRL2_MASK}, '{8'h1C, 32'h0000_FFFF, 8'h10, 32'hFFFF_0000},
    '{8'h00, 32'h4FFF_08F0, 8'h00, 32'h4FFF_08F0}, '{8'h10, 32'h0000_0001, 8'h10, 32'hFFFF_0000},
    '{8'h04, 32'hFFFF_FFFF, 8'h00, 32'h0000_0000}, '{8'h20, 32'hFFFF_FFFF, 8'h20, 32'h0000_0000},
    '{8'h30, 32'hFFFF_FFFF, 8'h30, 32'h0000_0000}, '{8'h08, 32'h0000_0800, 8'h0C, 32'h0000_0800},
    '{8'h0C, 32'h0000_0800, 8'h02, 32'h0000_0000}};
  logic [31:0] tb_cfg[8] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0002, 32'h0000_0023, 32'h0000_0033,
    32'h0003_0013, 32'h0003_0003, 32'h0003_2803};
  int tb_per[8] = '{16, 24, 32, 64, 256, 64, 4, 0};
  logic [3:0] codes[4] = '{4'h0, 4'h1, 4'h2, 4'hA};
  int al_exp[4] = '{16, 8, 0, 0};

  rtc_alarm_control_status u_dut (.I_CLK(clk), .I_RESET_N(reset_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WRITE(write), .I_READ(read), .O_RDATA(rdata), .I_CRYSTAL_OSC_32K(osc), .I_INTERNAL_LOW_RC(lrc),
    .I_LOW_FREQ_CLK_PIN(lfp), .I_TIME_VALUE(32'h0000_0000), .I_DATE_VALUE(date),
    .I_ALARM_TIME_VALUE(atime), .I_ALARM_DATE_VALUE(adate), .O_HALF_TICK(half),
    .O_SECOND_TICK(sec), .O_CALENDAR_RUN(run), .O_TIMEKEEP_WRITE_OK(wok), .O_ALARM_PULSE(alarm),
    .O_CLOCK_PIN(pin), .O_CLOCK_PIN_OE(oe));

  // ====================================================================
  // Stimulus helpers
  always #4 clk = ~clk;
  // Slow clock sources with periods of 16, 24 and 32 cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    osc <= cyc[3];
    lrc <= (cyc % 24) < 12;
    lfp <= cyc[4];
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    write <= 1'b1;
    @(posedge clk);
    write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    read <= 1'b1;
    @(posedge clk);
    read <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic wait_tick(input int sel);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 3000 && !hit; i++) begin
      @(posedge clk);
      #1;
      hit = (sel == 0 ? half : sel == 1 ? sec : alarm) === 1'b1;
    end
    check({31'h0, hit}, 32'h1);
  endtask
  // Alarm registers are only changed well clear of the update window.
  task automatic wr1(input logic [31:0] v);
    wait_tick(0);
    repeat (20) @(posedge clk);
    wr(8'h00, v);
  endtask
  task automatic period();
    per = 0;
    do begin
      @(posedge clk);
      #1;
      per++;
    end while (half !== 1'b1 && per < 3000);
  endtask
  task automatic count(input int n);
    logic last;
    n_alarm = 0;
    n_rise = 0;
    n_half = 0;
    #1;
    last = pin;
    repeat (n) begin
      @(posedge clk);
      #1;
      n_alarm += int'(alarm === 1'b1);
      n_half += int'(half === 1'b1);
      n_rise += int'(pin === 1'b1 && last === 1'b0);
      last = pin;
    end
  endtask
  task automatic results();
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ====================================================================
  // Sequence
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    results();
  end
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(8'(i * 16));
      check(d, 32'h0000_0000);
    end
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra);
      check(d, rows[i].ex);
    end
    wr(8'h08, 32'h0000_0800);
    rd(8'h00);
    check({31'h0, wok}, 32'h0);
    wr(8'h04, 32'h0000_0800);
    for (int i = 0; i < 8; i++) begin
      wr(8'h10, tb_cfg[i]);
      wr(8'h08, 32'h0000_8000);
      wait_tick(0);
      wait_tick(0);
      period();
      if (i < 7) check(per, tb_per[i]);
    end
    sum = per;
    repeat (31) begin
      period();
      sum += per;
    end
    check(sum, 133);
    check({31'h0, wok}, 32'h1);
    wr(8'h10, 32'h0003_0003);
    for (int i = 1; i < 3; i++) begin
      wr(8'h00, 32'h0000_8080 | (i << PIN_SEL_LSB));
      // Let the enabled pin settle so the enable itself is not counted as a rise.
      repeat (2) @(posedge clk);
      count(64);
      check(n_rise, i == 1 ? 8 : 32);
    end
    wr(8'h00, 32'h0000_8000);
    count(64);
    check({oe, n_rise[30:0]}, 32'h0);
    wr(8'h10, 32'h0003_0013);
    wr1(32'h8A00_8000);
    wait_tick(1);
    rd(8'h20);
    check(d, 32'h0000_0006);
    wait_tick(0);
    rd(8'h20);
    check(d, 32'h0000_0007);
    for (int i = 0; i < 4; i++) begin
      wr1(32'hC0FF_8080 | (32'(codes[i]) << INTERVAL_LSB));
      wait_tick(0);
      count(16 * 64);
      check(n_alarm, al_exp[i]);
      check(n_rise, al_exp[i]);
    end
    // A yearly alarm on the 29th of February matches only while the date shows that day.
    @(posedge clk);
    atime <= '0;
    date <= 32'h0002_2900;
    adate <= 32'h0002_2900;
    wr1(32'hC9FF_8000);
    wait_tick(0);
    count(16 * 64);
    check(n_alarm, 8);
    @(posedge clk);
    date <= 32'h0002_2800;
    count(16 * 64);
    check(n_alarm, 0);
    wr1(32'h8002_8000);
    count(20 * 64);
    check(n_alarm, 3);
    rd(8'h00);
    check(d, 32'h0000_8000);
    wr1(32'hC000_8000);
    wait_tick(2);
    rd(8'h00);
    check(d, 32'hC0FF_8000);
    rd(8'h20);
    check(d & 32'h0000_0020, 32'h0000_0020);
    wr1(32'h0000_8000);
    wr(8'h04, 32'h0000_8000);
    count(600);
    check({run, n_half[30:0]}, 32'h0);
    results();
  end
endmodule // test_rtc_alarm_control_status

bind rtc_alarm_control_status rtc_alarm_control_status_asserts u_chk (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WRITE(I_WRITE), .I_READ(I_READ), .O_RDATA(O_RDATA),
  .O_HALF_TICK(O_HALF_TICK), .O_SECOND_TICK(O_SECOND_TICK), .O_CALENDAR_RUN(O_CALENDAR_RUN),
  .O_TIMEKEEP_WRITE_OK(O_TIMEKEEP_WRITE_OK), .O_ALARM_PULSE(O_ALARM_PULSE), .O_CLOCK_PIN(O_CLOCK_PIN),
  .O_CLOCK_PIN_OE(O_CLOCK_PIN_OE));
